// [fb_restore.sv]
// Supply-return and disable-release state restore for one detection block
//
// Functional notes
// - Disable release in light-control mode: no motion, delay off, presence kept on.
// - Disable release in light-control mode is passed to the light-control block.
// - Standalone/main unit pick supply-return reaction from per-block setting.
// - No reaction, autonomous: basic state, no telegram.
// - No reaction, light control: basic state, presence indication off.
// - Disabled setting, autonomous: enter disable, send disable-start telegrams.
// - Entering disable on supply return saves basic state as prior state.
// - Disabled setting, light control: disable and signal it to light control.
// - Detection-start, autonomous: detect at once; twilight evaluation only sets the brightness mode.
// - Brightness-independent detection start: send start telegrams, start delay.
// - Brightness-dependent start: telegrams, delay; independent only below twilight.
// - Delay expiry without new motion runs end-of-detection processing.
// - Detection-start, light control: motion detected, presence on, delay started.
// - Restore-previous, autonomous: act on saved state; detection forces independent mode.
// - Running switch-off delay is not restarted; waits for threshold exceeded again.
// - Restore-previous, light control: saved state mapped to the other settings.
// - Skip reaction when block inactive or download reaction runs instead.
// - Basic state is no motion, delay off, disable off, no telegram.

`timescale 1ns/1ns
module fb_restore #(
  parameter int unsigned TX_DELAY_CYCLES = fb_restore_pkg::tx_delay_cycles
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic       i_supply_return,
  input  wire logic       i_download_reaction,
  input  wire logic       i_block_active,
  input  wire logic [1:0] i_block_type,
  input  wire logic [1:0] i_reaction_setting,
  input  wire logic       i_light_control_mode,
  input  wire logic       i_brightness_dependent,
  input  wire logic       i_below_twilight,
  input  wire logic       i_motion,
  input  wire logic       i_disable_set,
  input  wire logic       i_disable_release,
  input  wire logic       i_saved_motion,
  input  wire logic       i_saved_delay,
  input  wire logic       i_saved_disabled,
  input  wire logic       i_switch_off_exceeded,
  output logic            o_motion_state,
  output logic            o_delay_active,
  output logic            o_disabled,
  output logic            o_brightness_independent,
  output logic            o_presence_to_light,
  output logic            o_disable_to_light,
  output logic            o_disable_release_to_light,
  output logic            o_send_start_telegram,
  output logic            o_send_disable_telegram,
  output logic            o_end_of_detection,
  output logic            o_switch_off_delay_run,
  output logic            o_store_motion,
  output logic            o_store_delay,
  output logic            o_store_disabled,
  output logic            o_prior_motion,
  output logic            o_prior_delay,
  output logic            o_restore_busy
);

  // Effective reaction after mapping saved state
  // Three actions cover all four settings once the record is folded in
  typedef enum logic [1:0] {
    act_basic   = 2'b00,
    act_disable = 2'b01,
    act_detect  = 2'b10
  } action_t;

  fb_restore_pkg::restore_state_e state;
  fb_restore_pkg::restore_state_e next_state;
  action_t                        action;
  logic [fb_restore_pkg::cnt_w-1:0] delay_cnt;
  logic                           reacts;
  logic                           take_return;
  logic                           delay_expired;
  logic                           in_apply;
  logic                           apply_detect;
  logic                           apply_disable;
  logic                           release_hit;
  logic                           motion_hit;

  // Counter load and step values at the counter width
  // Load value is cut to the counter width; the default fits with room to spare
  localparam logic [fb_restore_pkg::cnt_w-1:0] delay_load =
    fb_restore_pkg::cnt_w'(TX_DELAY_CYCLES);
  localparam logic [fb_restore_pkg::cnt_w-1:0] cnt_one = 24'h00_0001;

  // Map setting and saved record to the action to carry out
  function automatic action_t map_action(input logic [1:0] setting, input logic s_dis, input logic s_mot,
                                         input logic s_dly);
    case (setting)
      fb_restore_pkg::react_disabled: begin
        // Interlocked on return
        map_action = act_disable;
      end
      fb_restore_pkg::react_detect: begin
        // Forced detection start
        map_action = act_detect;
      end
      fb_restore_pkg::react_previous: begin
        if (s_dis) begin
          map_action = act_disable;
        end else if (s_mot || s_dly) begin
          map_action = act_detect;
        end else begin
          map_action = act_basic;
        end
      end
      default: begin
        // No reaction: basic state
        map_action = act_basic;
      end
    endcase
  endfunction

  // Only standalone and main unit react, and only when active and no download reaction
  // Extension blocks follow their main unit, so a return is dropped without a sign
  assign reacts = (i_block_type == fb_restore_pkg::type_standalone) ||
                  (i_block_type == fb_restore_pkg::type_main_unit);
  assign take_return = i_supply_return && reacts && i_block_active && !i_download_reaction;
  assign delay_expired = o_delay_active && (delay_cnt == cnt_one) && !i_motion;
  assign o_restore_busy = (state != fb_restore_pkg::st_idle);

  // Apply-cycle decodes shared by the state, counter and pulse processes
  assign in_apply      = (state == fb_restore_pkg::st_apply);
  assign apply_detect  = in_apply && (action == act_detect);
  assign apply_disable = in_apply && (action == act_disable);

  // A release only counts while disabled; a stray enable is dropped
  assign release_hit = i_disable_release && o_disabled;

  // Fresh motion is ignored while the block is interlocked
  assign motion_hit = i_motion && !o_disabled;

  // Sequencer: decide the action, apply it for one cycle, then done
  // One decide cycle samples the setting and record before apply
  always_comb begin
    next_state = state;
    case (state)
      fb_restore_pkg::st_idle: begin
        // Leave idle only on an accepted supply return
        if (take_return) begin
          next_state = fb_restore_pkg::st_decide;
        end
      end
      fb_restore_pkg::st_decide: begin
        // Action is latched on this cycle
        next_state = fb_restore_pkg::st_apply;
      end
      fb_restore_pkg::st_apply: begin
        // Outputs take the chosen state on this cycle
        next_state = fb_restore_pkg::st_done;
      end
      fb_restore_pkg::st_done: begin
        // One spare cycle before a new return is accepted
        next_state = fb_restore_pkg::st_idle;
      end
      default: begin
        // Illegal code recovers to idle
        next_state = fb_restore_pkg::st_idle;
      end
    endcase
  end

  // Sequencer state register
  // Reset lands in idle so nothing is applied before a supply return
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= fb_restore_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Latch the chosen action; record sampled once so later edits do not disturb it
  // Held through apply, so a late change of the setting does not alter the action; brightness mode still reads it live
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      action <= act_basic;
    end else if (state == fb_restore_pkg::st_decide) begin
      action <= map_action(i_reaction_setting, i_saved_disabled, i_saved_motion, i_saved_delay);
    end
  end

  // Disable state: supply return first, then set, then release
  // Apply wins over a set or release in the same cycle, as the restore is newer
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_disabled <= 1'b0;
    end else if (in_apply) begin
      o_disabled <= (action == act_disable);
    end else if (i_disable_set && !o_disabled) begin
      o_disabled <= 1'b1;
    end else if (release_hit) begin
      o_disabled <= 1'b0;
    end
  end

  // Prior-state record, captured when a disable starts
  // A repeated set while disabled keeps the first record untouched
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prior_motion <= 1'b0;
      o_prior_delay  <= 1'b0;
    end else if (apply_disable) begin
      o_prior_motion <= 1'b0;
      o_prior_delay  <= 1'b0;
    end else if (i_disable_set && !o_disabled && !in_apply) begin
      o_prior_motion <= o_motion_state;
      o_prior_delay  <= o_delay_active;
    end
  end

  // Motion state, delay flag and brightness mode
  // Brightness mode only moves on a restore; live twilight tracking lies elsewhere
  // Expiry is checked after release so a release outside the apply cycle always lands in no motion
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_motion_state           <= 1'b0;
      o_delay_active           <= 1'b0;
      o_brightness_independent <= 1'b0;
    end else if (state == fb_restore_pkg::st_apply) begin
      if (action == act_detect) begin
        o_motion_state <= 1'b1;
        o_delay_active <= 1'b1;
        if (i_reaction_setting == fb_restore_pkg::react_previous || !i_brightness_dependent) begin
          o_brightness_independent <= 1'b1;
        end else begin
          o_brightness_independent <= i_below_twilight;
        end
      end else begin
        o_motion_state <= 1'b0;
        o_delay_active <= 1'b0;
      end
    end else if (release_hit) begin
      o_motion_state <= 1'b0;
      o_delay_active <= 1'b0;
    end else if (delay_expired) begin
      o_motion_state <= 1'b0;
      o_delay_active <= 1'b0;
    end else if (motion_hit) begin
      o_motion_state <= 1'b1;
      o_delay_active <= 1'b1;
    end
  end

  // Transmission delay counter, reloaded on start or fresh motion
  // Motion during a restore does not reload, so the restore decides the count
  // Counter parks at zero on expiry; a release or restore that drops the delay flag leaves it holding its count
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      delay_cnt <= '0;
    end else if (apply_detect || (motion_hit && state == fb_restore_pkg::st_idle)) begin
      delay_cnt <= delay_load;
    end else if (o_delay_active && delay_cnt != '0) begin
      delay_cnt <= delay_cnt - cnt_one;
    end
  end

  // Presence indication toward light control
  // Held low outside light-control mode so a mode change starts clean
  // Release drives it high; the light control decides what follows
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_presence_to_light <= 1'b0;
    end else if (!i_light_control_mode) begin
      o_presence_to_light <= 1'b0;
    end else if (state == fb_restore_pkg::st_apply) begin
      o_presence_to_light <= (action == act_detect);
    end else if (i_disable_release && o_disabled) begin
      o_presence_to_light <= 1'b1;
    end else if (delay_expired) begin
      o_presence_to_light <= 1'b0;
    end else if (i_motion && !o_disabled) begin
      o_presence_to_light <= 1'b1;
    end
  end

  // Disable indication level toward light control
  // One cycle behind the disable flag; the far side reacts on levels only
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_disable_to_light <= 1'b0;
    end else begin
      o_disable_to_light <= i_light_control_mode && o_disabled;
    end
  end

  // One-cycle event pulses
  // Registered so each pulse stands exactly one full cycle
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_send_start_telegram      <= 1'b0;
      o_send_disable_telegram    <= 1'b0;
      o_end_of_detection         <= 1'b0;
      o_disable_release_to_light <= 1'b0;
    end else begin
      // Telegrams only in autonomous operation; light control sends its own
      o_send_start_telegram   <= apply_detect && !i_light_control_mode;
      o_send_disable_telegram <= apply_disable && !i_light_control_mode;
      o_end_of_detection      <= delay_expired && !i_light_control_mode;
      o_disable_release_to_light <= release_hit && i_light_control_mode;
    end
  end

  // Switch-off delay: cleared on restore, rearmed only by threshold crossing
  // The saved record has no switch-off bit, so nothing could restart it anyway
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_switch_off_delay_run <= 1'b0;
    end else if (state == fb_restore_pkg::st_apply || o_disabled) begin
      o_switch_off_delay_run <= 1'b0;
    end else if (i_switch_off_exceeded) begin
      o_switch_off_delay_run <= 1'b1;
    end else if (!o_delay_active) begin
      o_switch_off_delay_run <= 1'b0;
    end
  end

  // Live record for the non-volatile store, saved by the outer system on failure
  // Plain copies; the store must take them before the supply sags too far
  always_comb begin
    o_store_motion   = o_motion_state;
    o_store_delay    = o_delay_active;
    o_store_disabled = o_disabled;
  end

endmodule

// [fb_restore_pkg.sv]
// Constants and types for the function block supply-return restore logic
package fb_restore_pkg;

  // Supply-return reaction setting encoding
  localparam logic [1:0] react_none     = 2'h0;
  localparam logic [1:0] react_disabled = 2'h1;
  localparam logic [1:0] react_detect   = 2'h2;
  localparam logic [1:0] react_previous = 2'h3;

  // Block type encoding; only standalone and main unit react
  localparam logic [1:0] type_standalone = 2'h0;
  localparam logic [1:0] type_main_unit  = 2'h1;
  localparam logic [1:0] type_extension  = 2'h2;

  // Transmission delay, in ms, and its cycle count at 100 MHz
  localparam int unsigned tx_delay_ms     = 1;
  localparam int unsigned clk_mhz         = 100;
  localparam int unsigned tx_delay_cycles = tx_delay_ms * 1000 * clk_mhz;
  localparam int unsigned cnt_w           = 24;

  // Restore sequencer states, one-hot
  typedef enum logic [3:0] {
    st_idle   = 4'b0001,
    st_decide = 4'b0010,
    st_apply  = 4'b0100,
    st_done   = 4'b1000
  } restore_state_e;

endpackage

// [fb_restore_props.sv]
// Assertions on the supply-return restore block ports
`timescale 1ns/1ns
module fb_restore_props (
  input wire logic       i_mclk,
  input wire logic       i_reset_n,
  input wire logic       i_supply_return,
  input wire logic       i_download_reaction,
  input wire logic       i_block_active,
  input wire logic [1:0] i_block_type,
  input wire logic [1:0] i_reaction_setting,
  input wire logic       i_light_control_mode,
  input wire logic       i_brightness_dependent,
  input wire logic       i_disable_release,
  input wire logic       o_motion_state,
  input wire logic       o_delay_active,
  input wire logic       o_disabled,
  input wire logic       o_presence_to_light,
  input wire logic       o_disable_to_light,
  input wire logic       o_disable_release_to_light,
  input wire logic       o_send_start_telegram,
  input wire logic       o_send_disable_telegram,
  input wire logic       o_prior_motion,
  input wire logic       o_prior_delay,
  input wire logic       o_restore_busy
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // Request the sequencer must accept
  logic take;
  assign take = i_supply_return && !i_block_type[1] && i_block_active && !i_download_reaction && !o_restore_busy;
  sequence s_go(logic [1:0] st, logic lc);
    take && i_reaction_setting == st && i_light_control_mode == lc;
  endsequence
  // Telegram outputs stay quiet over the whole restore
  sequence s_quiet;
    (!o_send_start_telegram && !o_send_disable_telegram)[*5];
  endsequence
  property p_take; take |=> o_restore_busy; endproperty
  a_take: assert property (p_take) else $error("restore not started");
  property p_skip; i_supply_return && (!i_block_active || i_download_reaction) && !o_restore_busy |=> !o_restore_busy;
  endproperty
  a_skip: assert property (p_skip) else $error("restore not skipped");
  property p_none_auto; s_go(2'h0, 1'b0) |-> s_quiet ##0 (!o_motion_state && !o_delay_active && !o_disabled);
  endproperty
  a_none_auto: assert property (p_none_auto) else $error("no-reaction state wrong");
  property p_none_lc; s_go(2'h0, 1'b1) |-> ##4 !o_presence_to_light && !o_motion_state; endproperty
  a_none_lc: assert property (p_none_lc) else $error("presence not cleared");
  property p_dis_auto; s_go(2'h1, 1'b0) |-> ##[2:4] o_send_disable_telegram; endproperty
  a_dis_auto: assert property (p_dis_auto) else $error("disable telegram missing");
  property p_prior; s_go(2'h1, 1'b0) |-> ##4 o_disabled && !o_prior_motion && !o_prior_delay; endproperty
  a_prior: assert property (p_prior) else $error("prior record not basic");
  property p_dis_lc; s_go(2'h1, 1'b1) |-> ##4 o_disabled && o_disable_to_light; endproperty
  a_dis_lc: assert property (p_dis_lc) else $error("disable not passed on");
  property p_det_lc; s_go(2'h2, 1'b1) |-> ##4 o_motion_state && o_presence_to_light && o_delay_active; endproperty
  a_det_lc: assert property (p_det_lc) else $error("light-control detection wrong");
  property p_det_auto; s_go(2'h2, 1'b0) ##0 !i_brightness_dependent |-> ##[2:4] o_send_start_telegram ##0 o_delay_active;
  endproperty
  a_det_auto: assert property (p_det_auto) else $error("detection start wrong");
  property p_release; i_disable_release && o_disabled && i_light_control_mode |-> ##[1:4] o_disable_release_to_light;
  endproperty
  a_release: assert property (p_release) else $error("release not passed on");
endmodule
bind fb_restore fb_restore_props u_props (.*);

// [light_ctrl_model.sv]
// Behavioural light-control block facing the restore logic
`timescale 1ns/1ns
module light_ctrl_model (
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic       i_presence,
  input  wire logic       i_disabled,
  input  wire logic       i_release,
  output logic            o_lamp_on,
  output logic [7:0]      o_release_count
);
  // Lamp follows presence unless interlocked; release reaction is its own business
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_lamp_on <= 1'b0;
      o_release_count <= 8'h00;
    end else begin
      o_lamp_on <= i_presence && !i_disabled;
      if (i_release) begin
        o_release_count <= o_release_count + 8'h01;
      end
    end
  end
endmodule

// [tb.sv]
// Self-checking testbench for the supply-return restore block
`timescale 1ns/1ns
module tb;
  logic i_mclk, i_reset_n, i_supply_return, i_download_reaction, i_block_active, i_light_control_mode;
  logic i_brightness_dependent, i_below_twilight, i_motion, i_disable_set, i_disable_release;
  logic i_saved_motion, i_saved_delay, i_saved_disabled, i_switch_off_exceeded;
  logic [1:0] i_block_type, i_reaction_setting;
  logic o_motion_state, o_delay_active, o_disabled, o_brightness_independent, o_presence_to_light;
  logic o_disable_to_light, o_disable_release_to_light, o_send_start_telegram, o_send_disable_telegram;
  logic o_end_of_detection, o_switch_off_delay_run, o_store_motion, o_store_delay, o_store_disabled;
  logic o_prior_motion, o_prior_delay, o_restore_busy, lamp_on, seen_start, seen_dis, seen_end, seen_rel;
  logic [7:0] rel_count;
  int err_count = 0;
  int num_checks = 0;
  // Short delay keeps the run brief
  fb_restore #(.TX_DELAY_CYCLES(20)) i_dut (.*);
  light_ctrl_model i_light (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_presence(o_presence_to_light),
    .i_disabled(o_disable_to_light), .i_release(o_disable_release_to_light), .o_lamp_on(lamp_on),
    .o_release_count(rel_count));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Latch one-cycle pulses so checks need not hit the exact cycle
  always @(posedge i_mclk) begin
    if (o_send_start_telegram) seen_start <= 1'b1;
    if (o_send_disable_telegram) seen_dis <= 1'b1;
    if (o_end_of_detection) seen_end <= 1'b1;
    if (o_disable_release_to_light) seen_rel <= 1'b1;
  end
  task automatic chk(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic st(input logic m, input logic d, input logic dis, input logic p);
    chk("motion", m, o_motion_state);
    chk("delay", d, o_delay_active);
    chk("disabled", dis, o_disabled);
    chk("presence", p, o_presence_to_light);
  endtask
  task automatic restore(input logic [1:0] ty, input logic [1:0] rs, input logic [7:0] f);
    @(posedge i_mclk);
    #1;
    {i_block_type, i_reaction_setting} = {ty, rs};
    {i_block_active, i_download_reaction, i_light_control_mode, i_brightness_dependent} = f[7:4];
    {i_below_twilight, i_saved_motion, i_saved_delay, i_saved_disabled} = f[3:0];
    {seen_start, seen_dis, seen_end, seen_rel} = 4'h0;
    i_supply_return = 1'b1;
    @(posedge i_mclk);
    #1;
    i_supply_return = 1'b0;
    repeat (6) @(posedge i_mclk);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog sized well above the roughly 160 cycles the tests need
  initial begin
    #20000;
    err_count++;
    test_done;
  end
  initial begin
    {i_supply_return, i_download_reaction, i_light_control_mode, i_brightness_dependent} = 4'h0;
    {i_below_twilight, i_motion, i_disable_set, i_disable_release, i_switch_off_exceeded} = 5'h00;
    {i_saved_motion, i_saved_delay, i_saved_disabled, i_block_type, i_reaction_setting} = 7'h00;
    i_block_active = 1'b1;
    i_reset_n = 1'b0;
    repeat (3) @(posedge i_mclk);
    #1 i_reset_n = 1'b1;
    restore(2'h0, 2'h2, 8'h80);
    st(1, 1, 0, 0);
    chk("start", 1, seen_start);
    chk("indep", 1, o_brightness_independent);
    repeat (30) @(posedge i_mclk);
    chk("end", 1, seen_end);
    st(0, 0, 0, 0);
    restore(2'h1, 2'h2, 8'h90);
    chk("start", 1, seen_start);
    chk("indep", 0, o_brightness_independent);
    restore(2'h0, 2'h0, 8'h80);
    st(0, 0, 0, 0);
    chk("start", 0, seen_start);
    restore(2'h0, 2'h2, 8'h80);
    restore(2'h0, 2'h1, 8'h80);
    st(0, 0, 1, 0);
    chk("dis tel", 1, seen_dis);
    chk("prior", 0, o_prior_motion | o_prior_delay);
    restore(2'h0, 2'h2, 8'hA0);
    st(1, 1, 0, 1);
    chk("start", 0, seen_start);
    chk("lamp", 1, lamp_on);
    restore(2'h0, 2'h1, 8'hA0);
    chk("dis light", 1, o_disable_to_light);
    chk("disabled", 1, o_disabled);
    i_disable_release = 1'b1;
    @(posedge i_mclk);
    #1 i_disable_release = 1'b0;
    repeat (5) @(posedge i_mclk);
    chk("release", 1, seen_rel);
    chk("rel count", 1, rel_count == 8'h01);
    st(0, 0, 0, 1);
    restore(2'h0, 2'h0, 8'hA0);
    st(0, 0, 0, 0);
    // Inactive block, download reaction, extension type: all ignored
    for (int k = 0; k < 3; k++) begin
      restore((k == 2) ? 2'h2 : 2'h0, 2'h2, {(k != 0), (k == 1), 6'h00});
      chk("skip", 0, o_motion_state | seen_start);
    end
    restore(2'h0, 2'h3, 8'h96);
    chk("start", 1, seen_start);
    chk("indep", 1, o_brightness_independent);
    chk("off run", 0, o_switch_off_delay_run);
    chk("store", 1, o_store_motion & o_store_delay);
    i_switch_off_exceeded = 1'b1;
    @(posedge i_mclk);
    #1 i_switch_off_exceeded = 1'b0;
    chk("off run", 1, o_switch_off_delay_run);
    restore(2'h0, 2'h3, 8'h81);
    chk("disabled", 1, o_disabled);
    chk("store dis", 1, o_store_disabled);
    restore(2'h0, 2'h3, 8'hA0);
    st(0, 0, 0, 0);
    restore(2'h0, 2'h3, 8'hA6);
    st(1, 1, 0, 1);
    test_done;
  end
endmodule
